// *** logic/cas_defs.vh ***
`ifndef CAS_DEFS_VH
`define CAS_DEFS_VH

// counter phase codes on i_cnt_phase
`define CAS_PH_ZERO      2'h0
`define CAS_PH_UP        2'h1
`define CAS_PH_PEAK      2'h2
`define CAS_PH_DOWN      2'h3

// register widths
`define CAS_EVEN_W       16
`define CAS_ODD_W        32
`define CAS_CNT_W        16

// channel count and per-channel packed field widths
`define CAS_NCH          2
`define CAS_MODE_W       2
`define CAS_PH_W         2

// action register reset value
`define CAS_ACT_RST      32'h0000_0000
`define CAS_EVEN_MASK    32'h0000_ffff

// flag control bit positions
`define CAS_FLG_ZERO     3
`define CAS_FLG_UP       2
`define CAS_FLG_PEAK     1
`define CAS_FLG_DOWN     0

// output action field low bit positions (two bits each)
`define CAS_OUT_ZERO_M   10
`define CAS_OUT_UP_M     8
`define CAS_OUT_PEAK_M   6
`define CAS_OUT_DOWN_M   4
`define CAS_OUT_ZERO_N   14
`define CAS_OUT_PEAK_N   12

// output action codes
`define CAS_ACT_HOLD     2'h0
`define CAS_ACT_HIGH     2'h1
`define CAS_ACT_LOW      2'h2
`define CAS_ACT_INV      2'h3

// buffer transfer modes
`define CAS_BUF_OFF      2'h0
`define CAS_BUF_ZERO     2'h1
`define CAS_BUF_PEAK     2'h2
`define CAS_BUF_BOTH     2'h3

// peak compare value in up/down mode
`define CAS_CMP_TOP      16'hffff

`endif

// *** logic/cas_compare_action_selector.v ***
// Contract
// - even register 16-bit halfword, odd 32-bit word
// - writes land in shadow buffer first
// - buffer mode 00 transfers right after write
// - buffered: transfer on counter stop or timing
// - reads return active value, not shadow
// - zero state: match 11:10/bit3, else 15:14
// - counting up: match 9:8/bit2, else hold
// - peak state: match 7:6/bit1, else 13:12
// - counting down: match 5:4/bit0, else hold
// - unassigned conditions hold output and flag
// - counter chosen by counter-select field
// - equal compare value always reports match
// - up/down mode, 0xffff matches at peak
// - extension: peak matches when compare >= count
// - extension: zero matches when compare <= count
// - reduced variant forces extension bit off
// - flag bit 1 sets flag, 0 holds
// - field 00 hold, 01 high, 10 low, 11 invert
// - mode 01 zero, 10 peak, 11 either
`timescale 1ns/1ps
`include "cas_defs.vh"

module cas_compare_action_selector (
    // clock and reset
    input  wire        i_clk,
    input  wire        i_rst_n,
    // action register write port
    input  wire        i_even_wr,
    input  wire [15:0] i_even_wr_data,
    input  wire        i_odd_wr,
    input  wire [31:0] i_odd_wr_data,
    // action register read data
    output wire [15:0] o_even_rd_data,
    output wire [31:0] o_odd_rd_data,
    // per-channel control, bit 0 even, bit 1 odd; buffer mode bits 1:0 even, 3:2 odd
    input  wire [3:0]  i_action_buffer_mode,
    input  wire [1:0]  i_match_extension,
    input  wire [1:0]  i_counter_select,
    input  wire        i_reduced_variant,
    // compare values, even in low half
    input  wire [31:0] i_compare_value,
    // two free running counters, counter 0 in low bits
    input  wire [31:0] i_cnt_value,
    input  wire [3:0]  i_cnt_phase,
    input  wire [1:0]  i_cnt_updown,
    input  wire [1:0]  i_cnt_stop,
    // flag clear from software, one pulse per channel
    input  wire [1:0]  i_match_flag_clr,
    // channel results
    output wire [1:0]  o_match,
    output wire [1:0]  o_match_flag,
    output wire [1:0]  o_compare_output
);

    // active action registers, read back directly
    reg  [31:0] act_even_ff;
    reg  [31:0] act_odd_ff;

    // per-channel transfer strobes and shadow words, gathered here so
    // the active registers need no reference into the generate scope
    wire [1:0]  xfer_ch;
    wire [63:0] shadow_ch;

    // reads bypass the shadow, so a pending buffered write stays
    // invisible until its transfer edge
    // active reads
    assign o_even_rd_data = act_even_ff[15:0];
    assign o_odd_rd_data  = act_odd_ff;

    // each channel: match, decode, flag and output, shadow buffer;
    // the odd channel decodes its low halfword only, its upper half
    // is stored and read back but never acts
    genvar ch;
    generate
        for (ch = 0; ch < `CAS_NCH; ch = ch + 1) begin : g_ch
            // per-channel state
            reg  [31:0] shadow_ff;
            reg         pend_ff;
            reg         flag_ff;
            reg         out_ff;
            reg  [31:0] nxt_shadow;
            reg         nxt_pend;
            reg         nxt_flag;
            reg         nxt_out;
            reg         xfer;
            reg         match;
            reg         flg_bit;
            reg  [1:0]  act;
            // per-channel decode nets
            wire        wr;
            wire [31:0] wr_data;
            wire [31:0] act_cur;
            wire [1:0]  mode;
            wire [15:0] cmp;
            wire [15:0] cnt;
            wire [1:0]  phase;
            wire        updown;
            wire        stop;
            wire        ext;

            // the upper half of the even shadow is zero filled, so the
            // odd-only fields can never act on the even channel
            // even register keeps only its low halfword
            assign wr      = (ch == 0) ? i_even_wr : i_odd_wr;
            assign wr_data = (ch == 0) ? {16'h0000, i_even_wr_data}
                                       : i_odd_wr_data;
            assign act_cur = (ch == 0) ? act_even_ff : act_odd_ff;
            // per-channel slices of the packed control and compare ports
            assign mode    = i_action_buffer_mode[`CAS_MODE_W*ch +:
                                                  `CAS_MODE_W];
            assign cmp     = i_compare_value[`CAS_CNT_W*ch +: `CAS_CNT_W];

            // a select change is seen at once, with no resync; change it
            // only while the channel is stopped
            // counter select picks counter 0 or 1
            assign cnt    = i_counter_select[ch] ?
                            i_cnt_value[`CAS_CNT_W +: `CAS_CNT_W] :
                            i_cnt_value[`CAS_CNT_W-1:0];
            assign phase  = i_counter_select[ch] ?
                            i_cnt_phase[`CAS_PH_W +: `CAS_PH_W] :
                            i_cnt_phase[`CAS_PH_W-1:0];
            assign updown = i_cnt_updown[i_counter_select[ch]];
            assign stop   = i_cnt_stop[i_counter_select[ch]];

            // reduced variant ignores the extension bit
            assign ext    = i_match_extension[ch] & ~i_reduced_variant;

            // match determination; the extra rules below can only add a
            // match, so plain equality is never masked by mode or extension
            // (all four checks read the same selected counter)
            always @* begin
                match = (cmp == cnt);
                // top value at peak in up/down mode
                if (updown && phase == `CAS_PH_PEAK &&
                    cmp == `CAS_CMP_TOP) begin
                    match = 1'b1;
                end
                if (ext && phase == `CAS_PH_PEAK && cmp >= cnt) begin
                    match = 1'b1;
                end
                if (ext && phase == `CAS_PH_ZERO && cmp <= cnt) begin
                    match = 1'b1;
                end
            end

            // condition decode picks the action field and flag bit;
            // odd channel runs independent, linked condition unused
            always @* begin
                act     = `CAS_ACT_HOLD;
                flg_bit = 1'b0;
                case (phase)
                    `CAS_PH_ZERO: begin
                        if (match) begin
                            act     = act_cur[`CAS_OUT_ZERO_M+1:
                                              `CAS_OUT_ZERO_M];
                            flg_bit = act_cur[`CAS_FLG_ZERO];
                        end else begin
                            act     = act_cur[`CAS_OUT_ZERO_N+1:
                                              `CAS_OUT_ZERO_N];
                        end
                    end
                    `CAS_PH_UP: begin
                        if (match) begin
                            act     = act_cur[`CAS_OUT_UP_M+1:
                                              `CAS_OUT_UP_M];
                            flg_bit = act_cur[`CAS_FLG_UP];
                        end
                    end
                    `CAS_PH_PEAK: begin
                        if (match) begin
                            act     = act_cur[`CAS_OUT_PEAK_M+1:
                                              `CAS_OUT_PEAK_M];
                            flg_bit = act_cur[`CAS_FLG_PEAK];
                        end else begin
                            act     = act_cur[`CAS_OUT_PEAK_N+1:
                                              `CAS_OUT_PEAK_N];
                        end
                    end
                    `CAS_PH_DOWN: begin
                        if (match) begin
                            act     = act_cur[`CAS_OUT_DOWN_M+1:
                                              `CAS_OUT_DOWN_M];
                            flg_bit = act_cur[`CAS_FLG_DOWN];
                        end
                    end
                    default: begin
                        act     = `CAS_ACT_HOLD;
                        flg_bit = 1'b0;
                    end
                endcase
            end

            // next flag and output level; a clear pulse meeting a set
            // loses, so software never misses an event that lands in
            // the same cycle
            always @* begin
                // set wins over a same-cycle clear
                nxt_flag = flag_ff;
                if (i_match_flag_clr[ch]) begin
                    nxt_flag = 1'b0;
                end
                if (flg_bit) begin
                    nxt_flag = 1'b1;
                end
                case (act)
                    `CAS_ACT_HIGH: nxt_out = 1'b1;
                    `CAS_ACT_LOW:  nxt_out = 1'b0;
                    `CAS_ACT_INV:  nxt_out = ~out_ff;
                    default:       nxt_out = out_ff;
                endcase
            end

            // shadow buffer and transfer timing; a write on a transfer
            // edge stays pending, so the older shadow goes active first
            // and the new word follows at the next transfer condition
            always @* begin
                // unbuffered copies the cycle after a write
                // buffered waits for stop or timing
                case (mode)
                    `CAS_BUF_OFF:  xfer = 1'b1;
                    `CAS_BUF_ZERO: xfer = stop | (phase == `CAS_PH_ZERO);
                    `CAS_BUF_PEAK: xfer = stop | (phase == `CAS_PH_PEAK);
                    default:       xfer = stop |
                                          (phase == `CAS_PH_ZERO) |
                                          (phase == `CAS_PH_PEAK);
                endcase
                xfer       = xfer & pend_ff;
                nxt_shadow = shadow_ff;
                nxt_pend   = pend_ff & ~xfer;
                // a write refills the shadow; newest write wins
                if (wr) begin
                    nxt_shadow = wr_data;
                    nxt_pend   = 1'b1;
                end
            end

            // shadow and pending flag clear too, so no stale word can
            // transfer after reset
            // flag and output update on the sampling edge
            always @(posedge i_clk or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    shadow_ff <= `CAS_ACT_RST;
                    pend_ff   <= 1'b0;
                    flag_ff   <= 1'b0;
                    out_ff    <= 1'b0;
                end else begin
                    shadow_ff <= nxt_shadow;
                    pend_ff   <= nxt_pend;
                    flag_ff   <= nxt_flag;
                    out_ff    <= nxt_out;
                end
            end

            // hand the transfer strobe and shadow word to the active
            // registers outside the loop
            assign xfer_ch[ch] = xfer;
            assign shadow_ch[`CAS_ODD_W*ch +: `CAS_ODD_W] = shadow_ff;

            // channel results, match straight from the decode logic
            assign o_match[ch]          = match;
            assign o_match_flag[ch]     = flag_ff;
            assign o_compare_output[ch] = out_ff;
        end
    endgenerate

    // active registers load from their shadow on transfer
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            act_even_ff <= `CAS_ACT_RST;
            act_odd_ff  <= `CAS_ACT_RST;
        end else begin
            // even: only the halfword survives the mask
            if (xfer_ch[0]) begin
                act_even_ff <= shadow_ch[`CAS_ODD_W-1:0] & `CAS_EVEN_MASK;
            end
            // odd: the whole word, upper half stored for read back
            if (xfer_ch[1]) begin
                act_odd_ff <= shadow_ch[2*`CAS_ODD_W-1:`CAS_ODD_W];
            end
        end
    end

endmodule // cas_compare_action_selector

// *** test/cas_cnt_model.sv ***
`timescale 1ns/1ps
module cas_cnt_model (
    // clock and reset
    input  wire        i_clk,
    input  wire        i_rst_n,
    // count control
    input  wire        i_run,
    input  wire        i_ud,
    input  wire        i_ld,
    input  wire [15:0] i_ld_val,
    input  wire        i_ld_dn,
    input  wire [15:0] i_top,
    input  wire [15:0] i_bot,
    // counter status
    output wire [15:0] o_val,
    output wire [1:0]  o_ph,
    output wire        o_stop
);
    reg [15:0] val_ff;
    reg        dn_ff;

    // load wins, so the bench can freeze a phase while running
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            val_ff <= 16'h0000;
            dn_ff <= 1'b0;
        end else if (i_ld) begin
            val_ff <= i_ld_val;
            dn_ff <= i_ld_dn;
        end else if (i_run) begin
            if (val_ff == i_top)
                dn_ff <= i_ud;
            else if (val_ff == i_bot)
                dn_ff <= 1'b0;
            if (val_ff == i_top && !i_ud)
                val_ff <= i_bot;
            else if (val_ff == i_top || (dn_ff && val_ff != i_bot))
                val_ff <= val_ff - 16'h0001;
            else
                val_ff <= val_ff + 16'h0001;
        end
    end

    // phase is a level, derived from position and direction
    assign o_val = val_ff;
    assign o_ph = (val_ff == i_bot) ? 2'h0 : (val_ff == i_top) ? 2'h2 :
                  dn_ff ? 2'h3 : 2'h1;
    assign o_stop = ~i_run;
endmodule // cas_cnt_model

// *** test/cas_monitor.sv ***
`timescale 1ns/1ps
`include "cas_defs.vh"
module cas_monitor (
    // clock and reset
    input wire        i_clk,
    input wire        i_rst_n,
    // watched inputs
    input wire        i_even_wr,
    input wire [15:0] i_even_wr_data,
    input wire [3:0]  i_action_buffer_mode,
    input wire [1:0]  i_counter_select,
    input wire        i_reduced_variant,
    input wire [31:0] i_compare_value,
    input wire [31:0] i_cnt_value,
    input wire [3:0]  i_cnt_phase,
    input wire [1:0]  i_cnt_updown,
    input wire [1:0]  i_match_flag_clr,
    // watched outputs
    input wire [15:0] o_even_rd_data,
    input wire [1:0]  o_match,
    input wire [1:0]  o_match_flag,
    input wire [1:0]  o_compare_output
);
    // even channel view of the selected counter
    wire        sel = i_counter_select[0];
    wire [15:0] cnt = sel ? i_cnt_value[31:16] : i_cnt_value[15:0];
    wire [1:0]  ph = sel ? i_cnt_phase[3:2] : i_cnt_phase[1:0];
    wire        ud = sel ? i_cnt_updown[1] : i_cnt_updown[0];
    wire [15:0] cmp = i_compare_value[15:0];
    wire        m = o_match[0];
    wire        q = o_compare_output[0];
    wire [15:0] act = o_even_rd_data;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    sequence s_wr;
        i_even_wr && i_action_buffer_mode[1:0] == `CAS_BUF_OFF;
    endsequence
    property p_wr;
        s_wr |=> ##1 (act == $past(i_even_wr_data, 2));
    endproperty
    property p_eq;
        (cmp == cnt) |-> m;
    endproperty
    property p_top;
        (ud && ph == `CAS_PH_PEAK && cmp == `CAS_CMP_TOP) |-> m;
    endproperty
    property p_noext;
        (i_reduced_variant && cmp != cnt && !(ud && cmp == `CAS_CMP_TOP))
            |-> !m;
    endproperty
    property p_zflag;
        (ph == `CAS_PH_ZERO && m && act[3]) |=> o_match_flag[0];
    endproperty
    property p_dflag;
        (ph == `CAS_PH_DOWN && m && act[0]) |=> o_match_flag[0];
    endproperty
    property p_inv;
        (ph == `CAS_PH_DOWN && m && act[5:4] == 2'h3) |=> q != $past(q);
    endproperty
    property p_peak;
        (ph == `CAS_PH_PEAK && !m && act[13:12] == 2'h3) |=> q != $past(q);
    endproperty
    property p_hold;
        (ph[0] && !m && !i_match_flag_clr[0])
            |=> $stable(q) && $stable(o_match_flag[0]);
    endproperty

    a_wr: assert property (p_wr) else $error("write not applied");
    a_eq: assert property (p_eq) else $error("equal without match");
    a_top: assert property (p_top) else $error("top not matched");
    a_noext: assert property (p_noext) else $error("extension on");
    a_zflag: assert property (p_zflag) else $error("flag not set");
    a_dflag: assert property (p_dflag) else $error("down flag off");
    a_inv: assert property (p_inv) else $error("no inversion");
    a_peak: assert property (p_peak) else $error("peak miss idle");
    a_hold: assert property (p_hold) else $error("hold broken");
endmodule // cas_monitor

bind cas_compare_action_selector cas_monitor u_mon (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_even_wr(i_even_wr),
    .i_even_wr_data(i_even_wr_data),
    .i_action_buffer_mode(i_action_buffer_mode),
    .i_counter_select(i_counter_select),
    .i_reduced_variant(i_reduced_variant),
    .i_compare_value(i_compare_value), .i_cnt_value(i_cnt_value),
    .i_cnt_phase(i_cnt_phase), .i_cnt_updown(i_cnt_updown),
    .i_match_flag_clr(i_match_flag_clr), .o_even_rd_data(o_even_rd_data),
    .o_match(o_match), .o_match_flag(o_match_flag),
    .o_compare_output(o_compare_output));

// *** test/tb_compare_action_selector.sv ***
`timescale 1ns/1ps
module tb_compare_action_selector;
    localparam [15:0] TOP = 16'h0010;
    localparam [15:0] BOT = 16'h0002;
    reg         clk = 1'b0;
    reg         rst_n, ewr, owr, red, ldn, q0;
    reg  [15:0] ewd, cmp, lv, d, old;
    reg  [31:0] owd;
    reg  [3:0]  bm;
    reg  [1:0]  ext, sel, ud, run, ld, clr, php;
    integer     k, n, err_total, checked;
    wire [15:0] erd, v0, v1;
    wire [31:0] ord;
    wire [1:0]  mt, fl, qo, ph0, ph1, stp;

    cas_cnt_model u_cnt0 (.i_clk(clk), .i_rst_n(rst_n), .i_run(run[0]),
        .i_ud(ud[0]), .i_ld(ld[0]), .i_ld_val(lv), .i_ld_dn(ldn),
        .i_top(TOP), .i_bot(BOT), .o_val(v0), .o_ph(ph0), .o_stop(stp[0]));
    cas_cnt_model u_cnt1 (.i_clk(clk), .i_rst_n(rst_n), .i_run(run[1]),
        .i_ud(ud[1]), .i_ld(ld[1]), .i_ld_val(lv), .i_ld_dn(ldn),
        .i_top(TOP), .i_bot(BOT), .o_val(v1), .o_ph(ph1), .o_stop(stp[1]));
    cas_compare_action_selector u_dut (.i_clk(clk), .i_rst_n(rst_n),
        .i_even_wr(ewr), .i_even_wr_data(ewd), .i_odd_wr(owr),
        .i_odd_wr_data(owd), .o_even_rd_data(erd), .o_odd_rd_data(ord),
        .i_action_buffer_mode(bm), .i_match_extension(ext),
        .i_counter_select(sel), .i_reduced_variant(red),
        .i_compare_value({16'h0fff, cmp}), .i_cnt_value({v1, v0}),
        .i_cnt_phase({ph1, ph0}), .i_cnt_updown(ud), .i_cnt_stop(stp),
        .i_match_flag_clr(clr), .o_match(mt), .o_match_flag(fl),
        .o_compare_output(qo));

    always #4 clk = ~clk;

    task chk(input string nm, input [63:0] s, input [63:0] e);
        checked = checked + 1;
        if (s !== e) begin
            err_total = err_total + 1;
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
        end
    endtask
    task cyc(input integer c);
        repeat (c) @(posedge clk);
        #1;
    endtask
    // whole value per write, never read-modify-write
    task wre(input [15:0] v);
        ewr = 1'b1;
        ewd = v;
        cyc(1);
        ewr = 1'b0;
        cyc(2);
    endtask
    // freeze a counter at a value; load keeps it there
    task st(input i, input [15:0] v, input dn);
        ld = 2'b01 << i;
        lv = v;
        ldn = dn;
        cyc(1);
    endtask
    task hit(input [15:0] c);
        q0 = qo[0];
        cmp = c;
        cyc(1);
        cmp = 16'h0fff;
    endtask
    task mx(input u, input x, input r, input [15:0] c, input e);
        ud[0] = u;
        ext[0] = x;
        red = r;
        cmp = c;
        cyc(1);
        chk("match", mt[0], e);
    endtask
    function [15:0] pv(input integer p);
        pv = p == 0 ? BOT : p == 2 ? TOP : 16'h0005;
    endfunction
    task stop_test;
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // watchdog at 12500 cycles, far beyond the under two hundred cycles needed
    initial begin
        #100000;
        err_total = err_total + 1;
        stop_test;
    end

    initial begin
        // action register left at zero from reset
        // unbuffered writes only while both counters stand still
        {rst_n, ewr, ewd, owr, owd, bm, ext, sel, ud, run, ld, clr} = 0;
        {red, ldn, lv} = 0;
        cmp = 16'h0fff;
        err_total = 0;
        checked = 0;
        cyc(6);
        rst_n = 1'b1;
        chk("reset", {erd, ord, fl, qo}, 0);
        owr = 1'b1;
        owd = 32'h8765_4321;
        cyc(1);
        owr = 1'b0;
        cyc(2);
        chk("odd", ord, 32'h8765_4321);
        wre(16'ha5c3);
        chk("even", erd, 16'ha5c3);
        $display("test registers done");
        for (k = 0; k < 4; k = k + 1) begin
            wre((16'h3 << (10 - 2 * k)) | (16'h1 << (3 - k)));
            st(0, pv(k), k == 3);
            clr = 2'b01;
            cyc(1);
            clr = 2'b00;
            hit(pv(k));
            chk("match out", qo[0], !q0);
            chk("match flag", fl[0], 1);
        end
        wre(16'hffff);
        for (k = 0; k < 4; k = k + 1) begin
            st(0, pv(k), k == 3);
            clr = 2'b01;
            cyc(1);
            clr = 2'b00;
            hit(16'h0fff);
            chk("miss out", qo[0], k[0] ? q0 : !q0);
            chk("miss flag", fl[0], 0);
        end
        for (k = 0; k < 4; k = k + 1) begin
            wre({10'h000, k[1:0], 4'h0});
            hit(pv(3));
            chk("code", qo[0], k == 0 ? q0 : k == 3 ? !q0 : k == 1);
        end
        $display("test actions done");
        st(0, TOP, 1'b0);
        mx(1, 0, 0, 16'hffff, 1);
        mx(0, 0, 0, 16'hffff, 0);
        mx(0, 1, 0, 16'h0011, 1);
        mx(0, 1, 1, 16'h0011, 0);
        st(0, BOT, 1'b0);
        mx(0, 1, 0, 16'h0001, 1);
        mx(0, 0, 0, 16'h0001, 0);
        st(1, 16'h0007, 1'b0);
        sel = 2'b01;
        mx(0, 0, 0, 16'h0007, 1);
        mx(0, 0, 0, BOT, 0);
        sel = 2'b00;
        mx(0, 0, 0, BOT, 1);
        cmp = 16'h0fff;
        // odd channel on counter 1: zero miss field on counter 0 drives it low, then up match drives high
        owr = 1'b1;
        owd = 32'h0000_8104;
        cyc(1);
        owr = 1'b0;
        cyc(2);
        sel = 2'b10;
        clr = 2'b10;
        st(1, 16'h0fff, 1'b0);
        clr = 2'b00;
        chk("odd idle", qo[1], 0);
        cyc(1);
        chk("odd match", mt[1], 1);
        chk("odd out", qo[1], 1);
        chk("odd flag", fl[1], 1);
        sel = 2'b00;
        $display("test match rules done");
        for (k = 1; k < 4; k = k + 1) begin
            // mode changes only while stopped
            run = 2'b00;
            bm = k[3:0];
            st(0, 16'h0005, 1'b0);
            run = 2'b01;
            old = erd;
            d = {4{k[3:0]}};
            wre(d);
            chk("hidden", erd, old);
            ld = 2'b00;
            n = 0;
            while (erd !== d && n < 40) begin
                php = ph0;
                cyc(1);
                n = n + 1;
            end
            chk("xfer", erd, d);
            chk("xfer phase", php, k == 1 ? 0 : 2);
        end
        st(0, 16'h0005, 1'b0);
        wre(16'h00aa);
        chk("stop hold", erd, 16'h3333);
        run = 2'b00;
        cyc(1);
        chk("stop xfer", erd, 16'h00aa);
        $display("test buffering done");
        stop_test;
    end
endmodule // tb_compare_action_selector
